// [src/dgw_glue.sv]
module dgw_glue #(
    parameter logic [18:0] BREAK_CYCLES = 19'(dgw_pkg::BRK_CYC),
    parameter logic [21:0] RESET_CYCLES = 22'(dgw_pkg::RST_CYC),
    parameter logic [22:0] WD_CYCLES = 23'(dgw_pkg::WD_CYC),
    parameter logic [16:0] WD_PULSE_CYCLES = 17'(dgw_pkg::WDP_CYC)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] cpu_addr_lo,
    input wire logic [7:0] cpu_addr_hi,
    input wire logic [7:0] cpu_data,
    input wire logic cpu_rd_n,
    input wire logic cpu_wr_n,
    input wire logic cpu_write_ctl_n,
    input wire logic receive_pin,
    input wire logic cable_absent,
    input wire logic manual_reset_n,
    input wire logic supply_droop,
    input wire logic cal_switch_enable,
    input wire logic strobe2_enable_n,
    input wire logic hv_supply_cmd_n,
    output logic ram_select_n,
    output logic ram_we_n,
    output logic ram_oe_n,
    output logic rom_select_n,
    output logic rom_oe_n,
    output logic cal_mem_select_n,
    output logic cal_mem_we_n,
    output logic output_latch_select,
    output logic [7:0] latch_data,
    output logic [6:0] strobe,
    output logic relay_clear,
    output logic hv_supply_strobe,
    output logic [7:0] indicator_n,
    output logic break_out,
    output logic nmi_n,
    output logic reset_request_n,
    output logic board_reset_n
);
    import dgw_pkg::*;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic dgw_region_t region(input logic [15:0] a);
        unique case (a[15:13])
            3'h1: region = DGW_REG_CAL;
            3'h2, 3'h3: region = DGW_REG_LATCH;
            3'h4, 3'h5: region = DGW_REG_RAM;
            3'h6, 3'h7: region = DGW_REG_ROM;
            default: region = DGW_REG_NONE;
        endcase
    endfunction

    dgw_state_t st_reg;
    dgw_state_t st_next;
    logic [15:0] addr;
    dgw_region_t reg_sel;
    logic strobe_any;
    logic wr_go;
    logic wr_ok;
    logic [31:0] stat_word;

    assign addr = {cpu_addr_hi[7:6], cpu_addr_hi[5:0], cpu_addr_lo};
    assign reg_sel = region(addr);
    assign strobe_any = !cpu_rd_n || !cpu_wr_n;

    assign ram_select_n = !((reg_sel == DGW_REG_RAM) && strobe_any);
    assign ram_we_n = cpu_write_ctl_n;
    assign ram_oe_n = !cpu_write_ctl_n;
    assign rom_select_n = !(reg_sel == DGW_REG_ROM);
    assign rom_oe_n = cpu_rd_n;
    assign cal_mem_select_n = !((reg_sel == DGW_REG_CAL) && strobe_any);
    assign cal_mem_we_n = !(!cpu_write_ctl_n && board_reset_n
        && st_reg.pin[PIN_CALSW]);
    assign output_latch_select = (reg_sel == DGW_REG_LATCH) && !cpu_wr_n;

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign latch_data = st_reg.latch_data;
    assign strobe = st_reg.ctrl[6:0];
    assign relay_clear = st_reg.ctrl[CTRL_CLR_BIT];
    assign hv_supply_strobe = st_reg.ctrl[HB_BIT] && !strobe2_enable_n
        && !hv_supply_cmd_n;
    assign indicator_n = st_reg.indicator_n;
    assign break_out = st_reg.break_q;
    assign nmi_n = !(st_reg.break_q || st_reg.pin[PIN_CABLE]);
    assign reset_request_n = (st_reg.os2_cnt == 17'h00000);
    assign board_reset_n = (st_reg.rst_cnt == 22'h000000);

    assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_got && !st_reg.bvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    assign stat_word = {26'h0000000, st_reg.wd_fired, !reset_request_n, board_reset_n,
        st_reg.pin[PIN_CABLE], st_reg.pin[PIN_CALSW], st_reg.break_q};

    always_comb begin
        st_next = st_reg;
        wr_go = 1'b0;
        wr_ok = 1'b0;
        // ----------------------------------------
        // pin synchronisers, change once stages two and three agree
        // ----------------------------------------
        st_next.s1 = {cal_switch_enable, supply_droop, manual_reset_n, cable_absent,
            receive_pin};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < 5; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.pin[i] = st_reg.s3[i];
            end
        end
        // ----------------------------------------
        // output latch and indicator latch
        // ----------------------------------------
        if (output_latch_select) begin
            st_next.latch_data = cpu_data;
        end
        if (st_reg.ctrl[CTRL_IND_BIT]) begin
            st_next.indicator_n = st_reg.latch_data;
        end
        // ----------------------------------------
        // break detector
        // ----------------------------------------
        if (st_reg.pin[PIN_RX]) begin
            st_next.brk_cnt = 19'h00000;
            st_next.break_q = 1'b0;
        end else if (st_reg.brk_cnt >= BREAK_CYCLES) begin
            st_next.break_q = 1'b1;
        end else begin
            st_next.brk_cnt = st_reg.brk_cnt + 19'h00001;
        end
        // ----------------------------------------
        // reset generator
        // ----------------------------------------
        if (st_reg.pin[PIN_DROOP] || !st_reg.pin[PIN_MANUAL_N] || !reset_request_n
            || st_reg.break_q) begin
            st_next.rst_cnt = RESET_CYCLES;
        end else if (st_reg.rst_cnt != 22'h000000) begin
            st_next.rst_cnt = st_reg.rst_cnt - 22'h000001;
        end
        st_next.board_rst_n_d = board_reset_n;
        // ----------------------------------------
        // watchdog one-shots
        // ----------------------------------------
        st_next.hb_d = st_reg.ctrl[HB_BIT];
        if (!board_reset_n) begin
            st_next.os1_cnt = 23'h000000;
        end else if ((board_reset_n && !st_reg.board_rst_n_d)
            || (st_reg.ctrl[HB_BIT] != st_reg.hb_d)) begin
            st_next.os1_cnt = WD_CYCLES;
        end else if (st_reg.os1_cnt != 23'h000000) begin
            st_next.os1_cnt = st_reg.os1_cnt - 23'h000001;
        end
        st_next.os1_q = (st_next.os1_cnt != 23'h000000);
        if (st_reg.os1_q && !st_next.os1_q && board_reset_n) begin
            st_next.os2_cnt = WD_PULSE_CYCLES;
            st_next.wd_fired = 1'b1;
        end else if (st_reg.os2_cnt != 17'h00000) begin
            st_next.os2_cnt = st_reg.os2_cnt - 17'h00001;
        end
        // ----------------------------------------
        // axi write channel
        // ----------------------------------------
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            wr_go = 1'b1;
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = RESP_OKAY;
            unique case (st_reg.awaddr)
                CTRL_OFS: begin
                    wr_ok = 1'b1;
                    if (st_reg.wstrb[0]) begin
                        st_next.ctrl[7:0] = st_reg.wdata[7:0];
                    end
                    if (st_reg.wstrb[1]) begin
                        st_next.ctrl[8] = st_reg.wdata[8];
                    end
                end
                STAT_OFS: begin
                    wr_ok = 1'b1;
                end
                LATCH_OFS: begin
                    wr_ok = 1'b1;
                end
                default: st_next.bresp = RESP_SLVERR;
            endcase
        end
        if (wr_go && wr_ok && st_reg.awaddr == STAT_OFS && st_reg.wstrb[0]
            && st_reg.wdata[STAT_WD_BIT] && !(st_reg.os1_q && !st_next.os1_q)) begin
            st_next.wd_fired = 1'b0;
        end
        if (!board_reset_n) begin
            st_next.ctrl = CTRL_RST;
        end
        // ----------------------------------------
        // axi read channel
        // ----------------------------------------
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_reg.rvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                CTRL_OFS: st_next.rdata = {23'h000000, st_reg.ctrl};
                STAT_OFS: st_next.rdata = stat_word;
                LATCH_OFS: st_next.rdata = {16'h0000, st_reg.indicator_n, st_reg.latch_data};
                default: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.s1 <= PIN_RST;
            st_reg.s2 <= PIN_RST;
            st_reg.s3 <= PIN_RST;
            st_reg.pin <= PIN_RST;
            st_reg.ctrl <= CTRL_RST;
            st_reg.indicator_n <= 8'hFF;
            st_reg.rst_cnt <= RESET_CYCLES;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // dgw_glue

// [src/dgw_pkg.sv]
package dgw_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int BREAK_TIME_US = 13340;
    localparam int RESET_TIME_US = 130000;
    localparam int WD_TIME_US = 300000;
    localparam int WD_PULSE_US = 3000;
    localparam int BRK_CYC = (BREAK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CYC = (RESET_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_CYC = (WD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDP_CYC = (WD_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] LATCH_OFS = 8'h08;
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam int CTRL_CLR_BIT = 7;
    localparam int CTRL_IND_BIT = 8;
    localparam int HB_BIT = 1;
    localparam int STAT_WD_BIT = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------
    // pins and address regions
    // ----------------------------------------
    localparam int PIN_RX = 0;
    localparam int PIN_CABLE = 1;
    localparam int PIN_MANUAL_N = 2;
    localparam int PIN_DROOP = 3;
    localparam int PIN_CALSW = 4;
    localparam logic [4:0] PIN_RST = 5'h05;
    typedef enum logic [2:0] {
        DGW_REG_NONE = 3'h0,
        DGW_REG_CAL = 3'h1,
        DGW_REG_LATCH = 3'h2,
        DGW_REG_RAM = 3'h3,
        DGW_REG_ROM = 3'h4
    } dgw_region_t;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] s3;
        logic [4:0] pin;
        logic [8:0] ctrl;
        logic wd_fired;
        logic [7:0] latch_data;
        logic [7:0] indicator_n;
        logic [18:0] brk_cnt;
        logic break_q;
        logic [21:0] rst_cnt;
        logic board_rst_n_d;
        logic [22:0] os1_cnt;
        logic os1_q;
        logic [16:0] os2_cnt;
        logic hb_d;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dgw_state_t;
endpackage

// [verification/dgw_host.sv]
// ----------------------------------------
// host side of the serial receive line
// ----------------------------------------
module dgw_host (
    input wire logic aclk,
    output logic receive_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial receive_pin = 1'h1;
    task automatic go_low();
        @(posedge aclk);
        receive_pin <= 1'h0;
    endtask
    task automatic go_high();
        @(posedge aclk);
        receive_pin <= 1'h1;
    endtask
endmodule // dgw_host

// [verification/dgw_glue_chk.sv]
// ----------------------------------------
// port checker
// ----------------------------------------
module dgw_glue_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] cpu_addr_hi,
    input wire logic [7:0] cpu_data,
    input wire logic cpu_rd_n,
    input wire logic cpu_wr_n,
    input wire logic cpu_write_ctl_n,
    input wire logic receive_pin,
    input wire logic strobe2_enable_n,
    input wire logic hv_supply_cmd_n,
    input wire logic ram_select_n,
    input wire logic rom_select_n,
    input wire logic cal_mem_select_n,
    input wire logic cal_mem_we_n,
    input wire logic output_latch_select,
    input wire logic [7:0] latch_data,
    input wire logic [6:0] strobe,
    input wire logic hv_supply_strobe,
    input wire logic break_out,
    input wire logic nmi_n,
    input wire logic reset_request_n,
    input wire logic board_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wd_fire;
        reset_request_n ##1 !reset_request_n;
    endsequence
    a_ram_decode: assert property (!ram_select_n == (cpu_addr_hi[7:6] == 2'h2 && !(cpu_rd_n && cpu_wr_n)))
        else $error("ram select mismatch");
    a_rom_decode: assert property (!rom_select_n == (cpu_addr_hi[7:6] == 2'h3))
        else $error("rom select mismatch");
    a_cal_decode: assert property (!cal_mem_select_n == (cpu_addr_hi[7:5] == 3'h1 && !(cpu_rd_n && cpu_wr_n)))
        else $error("cal select mismatch");
    a_latch_decode: assert property (output_latch_select == (cpu_addr_hi[7:6] == 2'h1 && !cpu_wr_n))
        else $error("latch select mismatch");
    a_one_select: assert property ($onehot0({!ram_select_n, !rom_select_n, !cal_mem_select_n, output_latch_select}))
        else $error("several selects active");
    a_latch_load: assert property (output_latch_select |=> latch_data == $past(cpu_data))
        else $error("latch missed data");
    a_cal_gate: assert property (!cal_mem_we_n |-> board_reset_n && !cpu_write_ctl_n)
        else $error("cal write not gated");
    a_hv_strobe: assert property (hv_supply_strobe == (strobe[1] && !strobe2_enable_n && !hv_supply_cmd_n))
        else $error("supply strobe mismatch");
    a_nmi_nor: assert property (break_out |-> !nmi_n)
        else $error("break without nmi");
    a_break_idle: assert property (receive_pin [*6] |-> !break_out)
        else $error("break while line idle");
    a_req_reset: assert property (s_wd_fire |-> ##[0:4] !board_reset_n)
        else $error("watchdog request without reset");
    a_reset_hold: assert property ($fell(board_reset_n) |=> !board_reset_n [*8])
        else $error("board reset too short");
endmodule // dgw_glue_chk
bind dgw_glue dgw_glue_chk u_chk (.*);

// [verification/dgw_glue_bench.sv]
module dgw_glue_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import dgw_pkg::*;
    logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, cpu_rd_n = '1, cpu_wr_n = '1, cpu_write_ctl_n = '1;
    logic cable_absent = '0, manual_reset_n = '1, supply_droop = '0, cal_switch_enable = '0;
    logic strobe2_enable_n = '0, hv_supply_cmd_n = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, cpu_addr_lo = '0, cpu_addr_hi = '0, cpu_data = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic ram_select_n, ram_we_n, ram_oe_n, rom_select_n, rom_oe_n, cal_mem_select_n, cal_mem_we_n;
    logic output_latch_select, relay_clear, hv_supply_strobe, break_out, nmi_n, reset_request_n;
    logic board_reset_n;
    logic [6:0] strobe;
    logic [7:0] latch_data, indicator_n;
    wire logic receive_pin;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // rows: address high byte, read and write strobes, expected ram, rom, cal selects and latch
    localparam logic [13:0] ROWS [10] = '{{8'h80, 2'h1, 4'h6}, {8'hBF, 2'h2, 4'h6},
        {8'h80, 2'h3, 4'hE}, {8'hC0, 2'h3, 4'hA}, {8'hFF, 2'h1, 4'hA}, {8'h20, 2'h1, 4'hC},
        {8'h3F, 2'h2, 4'hC}, {8'h1F, 2'h1, 4'hE}, {8'h40, 2'h2, 4'hF}, {8'h7F, 2'h1, 4'hE}};
    always #20 aclk = ~aclk;
    dgw_glue #(.BREAK_CYCLES(19'h28), .RESET_CYCLES(22'h32), .WD_CYCLES(23'hC8),
        .WD_PULSE_CYCLES(17'h5)) i_dut (.*);
    dgw_host i_host (.aclk(aclk), .receive_pin(receive_pin));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = (s_axi_bvalid === 1'h1);
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'h0;
            if (w_hs) s_axi_wvalid <= 1'h0;
        end while (!b_hs);
        s_axi_bready <= 1'h0;
    endtask
    task automatic axr(input logic [7:0] a);
        logic ar_hs;
        logic r_hs;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = (s_axi_rvalid === 1'h1);
            rdv = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'h0;
        end while (!r_hs);
        s_axi_rready <= 1'h0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            conclude();
        end
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        tick(8);
        aresetn <= 1'h1;
        @(negedge aclk);
        chk(32'(board_reset_n), 32'h0);
        while (board_reset_n !== 1'h1) tick(1);
        $display("test reset done");
        foreach (ROWS[i]) begin
            tick(1);
            cpu_addr_hi <= ROWS[i][13:6];
            {cpu_rd_n, cpu_wr_n} <= ROWS[i][5:4];
            @(negedge aclk);
            chk(32'({ram_select_n, rom_select_n, cal_mem_select_n, output_latch_select}), 32'(ROWS[i][3:0]));
        end
        $display("test decode done");
        axw(CTRL_OFS, 32'h182);
        @(negedge aclk);
        chk(32'({relay_clear, strobe}), 32'h82);
        chk(32'(hv_supply_strobe), 32'h1);
        tick(1);
        hv_supply_cmd_n <= 1'h1;
        @(negedge aclk);
        chk(32'(hv_supply_strobe), 32'h0);
        axr(8'h0C);
        chk({rdv[29:0], rsp}, 32'(RESP_SLVERR));
        axr(CTRL_OFS);
        chk(rdv, 32'h182);
        tick(1);
        cpu_addr_hi <= 8'h40;
        cpu_data <= 8'hA5;
        cpu_rd_n <= 1'h1;
        cpu_wr_n <= 1'h0;
        tick(1);
        cpu_wr_n <= 1'h1;
        cpu_data <= 8'h5A;
        tick(2);
        axr(LATCH_OFS);
        chk(rdv, 32'hA5A5);
        $display("test latch done");
        cpu_addr_hi <= 8'h20;
        cpu_wr_n <= 1'h0;
        cpu_write_ctl_n <= 1'h0;
        tick(5);
        @(negedge aclk);
        chk(32'(cal_mem_we_n), 32'h1);
        chk(32'({ram_we_n, ram_oe_n, rom_oe_n}), 32'h3);
        tick(1);
        cal_switch_enable <= 1'h1;
        tick(5);
        @(negedge aclk);
        chk(32'(cal_mem_we_n), 32'h0);
        axr(STAT_OFS);
        chk(32'(rdv[1]), 32'h1);
        cpu_wr_n <= 1'h1;
        cpu_write_ctl_n <= 1'h1;
        cable_absent <= 1'h1;
        tick(5);
        @(negedge aclk);
        chk(32'(nmi_n), 32'h0);
        tick(1);
        cable_absent <= 1'h0;
        i_host.go_low();
        tick(30);
        @(negedge aclk);
        chk(32'(break_out), 32'h0);
        i_host.go_high();
        tick(8);
        i_host.go_low();
        tick(50);
        @(negedge aclk);
        chk(32'({break_out, nmi_n, board_reset_n}), 32'h4);
        i_host.go_high();
        $display("test break done");
        while (board_reset_n !== 1'h1) tick(1);
        while (reset_request_n !== 1'h0) tick(1);
        tick(3);
        @(negedge aclk);
        chk(32'(board_reset_n), 32'h0);
        while (board_reset_n !== 1'h1) tick(1);
        axr(STAT_OFS);
        chk(32'(rdv[STAT_WD_BIT]), 32'h1);
        $display("test watchdog done");
        tick(1);
        manual_reset_n <= 1'h0;
        tick(6);
        manual_reset_n <= 1'h1;
        @(negedge aclk);
        chk(32'(board_reset_n), 32'h0);
        while (board_reset_n !== 1'h1) tick(1);
        supply_droop <= 1'h1;
        tick(6);
        supply_droop <= 1'h0;
        @(negedge aclk);
        chk(32'(board_reset_n), 32'h0);
        while (board_reset_n !== 1'h1) tick(1);
        $display("test reset sources done");
        conclude();
    end
endmodule // dgw_glue_bench
